//--- hw/lnbps_serial.sv
// Two-wire serial slave engine: chip address match, register pointer,
// auto-incrementing byte writes and reads.
// Assumes scl and sda are far slower than mclk.
`timescale 1ns/1ps
module lnbps_serial (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    lnbps_reg_if.engine bus
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] pin_in;
    logic [1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
    logic [1:0] filt_nxt;

    assign pin_in = {scl_i, sda_i};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            // A change counts only once the last two stages agree
            always_comb begin
                filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= 2'h3;
            s2_r <= 2'h3;
            s3_r <= 2'h3;
            filt_r <= 2'h3;
            prev_r <= 2'h3;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
    assign scl = filt_r[1];
    assign sda = filt_r[0];
    assign scl_rise = scl & ~prev_r[1];
    assign scl_fall = ~scl & prev_r[1];
    assign start_ev = scl & prev_r[1] & ~sda & prev_r[0];
    assign stop_ev = scl & prev_r[1] & sda & ~prev_r[0];

    // ************************************************************
    // Byte engine
    // ************************************************************
    lnbps_pkg::lnbps_ser_st_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
    logic rw_r, rw_nxt, ack_r, ack_nxt, oe_r, oe_nxt, wr_r, wr_nxt;
    logic sda_o_r;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        ack_nxt = ack_r;
        oe_nxt = oe_r;
        wr_nxt = 1'b0;
        if (stop_ev) begin
            st_nxt = lnbps_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end else if (start_ev) begin
            st_nxt = lnbps_pkg::ST_DEV;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (scl_rise) begin
            if (st_r == lnbps_pkg::ST_DEV || st_r == lnbps_pkg::ST_PTR ||
                st_r == lnbps_pkg::ST_WR) begin
                sh_nxt = {sh_r[6:0], sda};
                cnt_nxt = 4'(cnt_r + 4'h1);
            end else if (st_r == lnbps_pkg::ST_RD) begin
                cnt_nxt = 4'(cnt_r + 4'h1);
            end else if (st_r == lnbps_pkg::ST_RD_ACK) begin
                // Master holding ack low asks for the next register
                ack_nxt = ~sda;
                if (!sda) begin
                    ptr_nxt = ptr_r + 8'h01;
                end
            end
        end else if (scl_fall) begin
            unique case (st_r)
                lnbps_pkg::ST_IDLE: begin
                end
                lnbps_pkg::ST_DEV: begin
                    if (cnt_r == lnbps_pkg::BITS_PER_BYTE) begin
                        if (sh_r[7:1] == lnbps_pkg::CHIP_ADDR) begin
                            oe_nxt = 1'b1;
                            rw_nxt = sh_r[0];
                            st_nxt = lnbps_pkg::ST_DEV_ACK;
                        end else begin
                            st_nxt = lnbps_pkg::ST_IDLE;
                        end
                    end
                end
                lnbps_pkg::ST_DEV_ACK: begin
                    cnt_nxt = 4'h0;
                    if (rw_r) begin
                        tx_nxt = bus.rd_data;
                        oe_nxt = ~bus.rd_data[7];
                        st_nxt = lnbps_pkg::ST_RD;
                    end else begin
                        oe_nxt = 1'b0;
                        st_nxt = lnbps_pkg::ST_PTR;
                    end
                end
                lnbps_pkg::ST_PTR: begin
                    if (cnt_r == lnbps_pkg::BITS_PER_BYTE) begin
                        ptr_nxt = sh_r;
                        oe_nxt = 1'b1;
                        st_nxt = lnbps_pkg::ST_PTR_ACK;
                    end
                end
                lnbps_pkg::ST_PTR_ACK, lnbps_pkg::ST_WR_ACK: begin
                    // Pointer moves only after the written byte is acked
                    if (st_r == lnbps_pkg::ST_WR_ACK) begin
                        ptr_nxt = ptr_r + 8'h01;
                    end
                    oe_nxt = 1'b0;
                    cnt_nxt = 4'h0;
                    st_nxt = lnbps_pkg::ST_WR;
                end
                lnbps_pkg::ST_WR: begin
                    if (cnt_r == lnbps_pkg::BITS_PER_BYTE) begin
                        wr_nxt = 1'b1;
                        oe_nxt = 1'b1;
                        st_nxt = lnbps_pkg::ST_WR_ACK;
                    end
                end
                lnbps_pkg::ST_RD: begin
                    if (cnt_r == lnbps_pkg::BITS_PER_BYTE) begin
                        oe_nxt = 1'b0;
                        st_nxt = lnbps_pkg::ST_RD_ACK;
                    end else begin
                        tx_nxt = {tx_r[6:0], 1'b0};
                        oe_nxt = ~tx_r[6];
                    end
                end
                lnbps_pkg::ST_RD_ACK: begin
                    cnt_nxt = 4'h0;
                    if (ack_r) begin
                        tx_nxt = bus.rd_data;
                        oe_nxt = ~bus.rd_data[7];
                        st_nxt = lnbps_pkg::ST_RD;
                    end else begin
                        oe_nxt = 1'b0;
                        st_nxt = lnbps_pkg::ST_IDLE;
                    end
                end
                default: begin
                    oe_nxt = 1'b0;
                    st_nxt = lnbps_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= lnbps_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            oe_r <= 1'b0;
            wr_r <= 1'b0;
            sda_o_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            oe_r <= oe_nxt;
            wr_r <= wr_nxt;
            sda_o_r <= 1'b0;
        end
    end

    assign sda_o = sda_o_r;
    assign sda_oe = oe_r;
    assign bus.addr = ptr_r;
    assign bus.wr_en = wr_r;
    assign bus.wr_data = sh_r;

endmodule : lnbps_serial

//--- hw/lnbps_pkg.sv
// Package for the supply protection and status register slice.
// Assumes one clock (mclk) and a byte-wide register space behind the
// two-wire serial port.
package lnbps_pkg;

    // ************************************************************
    // Register indices on the serial port
    // ************************************************************
    localparam logic [7:0] IDX_DIAG = 8'h00;
    localparam logic [7:0] IDX_SPARE = 8'h01;
    localparam logic [7:0] IDX_OUTPUT_VOLTAGE_SELECT = 8'h02;
    localparam logic [7:0] IDX_TONE = 8'h03;
    localparam logic [7:0] IDX_PULSE = 8'h04;
    localparam logic [7:0] IDX_POLICY = 8'h05;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POL_OVL_RESTART = 3;
    localparam int POL_THERMAL_RESTART_POLICY_RESTART = 6;
    localparam int POL_COMP = 7;
    localparam int PCL_A = 2;
    localparam int PCL_B = 6;
    localparam int DIAG_OVL_A = 0;
    localparam int DIAG_OVL_B = 1;
    localparam int DIAG_OVERHEAT = 6;
    localparam int DIAG_LOW_SUPPLY = 7;

    // ************************************************************
    // Reset values and serial port constants
    // ************************************************************
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Arbitrary chip address value
    localparam logic [6:0] CHIP_ADDR = 7'h2a;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int PIN_SYNC_STAGES = 3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV = 4'h1,
        ST_DEV_ACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PTR_ACK = 4'h4,
        ST_WR = 4'h5,
        ST_WR_ACK = 4'h6,
        ST_RD = 4'h7,
        ST_RD_ACK = 4'h8
    } lnbps_ser_st_t;

endpackage : lnbps_pkg

//--- hw/lnbps_reg_if.sv
// Byte register access between the serial engine and the register bank.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface lnbps_reg_if;
    logic [7:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    modport engine (output addr, output wr_en, output wr_data,
                    input rd_data);
    modport bank (input addr, input wr_en, input wr_data,
                  output rd_data);
endinterface : lnbps_reg_if

//--- hw/lnbps_regs.sv
// Protection policy and diagnostic status registers of a dual-channel
// antenna supply controller, reached over the two-wire serial port.
// Assumes the detector inputs are asynchronous analog comparator levels.
`timescale 1ns/1ps
module lnbps_regs (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic overload_det_a,
    input wire logic overload_det_b,
    input wire logic overheat_det,
    input wire logic low_supply_detector,
    output logic [3:0] output_voltage_select_a,
    output logic [3:0] output_voltage_select_b,
    output logic antenna_supply_output_en_a,
    output logic antenna_supply_output_en_b,
    output logic boost_comp_low_esr,
    output logic pulse_limit_disable_a,
    output logic pulse_limit_disable_b,
    output logic [7:0] tone_ctrl
);

    // ************************************************************
    // Serial port
    // ************************************************************
    lnbps_reg_if bus ();

    lnbps_serial u_serial (
        .mclk(mclk),
        .reset_n(reset_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .bus(bus)
    );

    // ************************************************************
    // Detector synchronisers
    // ************************************************************
    // Order: overload A, overload B, overheat, low supply
    logic [3:0] det_in;
    logic [3:0] d1_r, d2_r, d3_r, flag_r;
    logic [3:0] flag_nxt;

    assign det_in = {low_supply_detector, overheat_det,
                     overload_det_b, overload_det_a};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_det
            // Live level, no latching; glitch shorter than a cycle ignored
            always_comb begin
                flag_nxt[g] = (d2_r[g] == d3_r[g]) ? d3_r[g] : flag_r[g];
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            d1_r <= 4'h0;
            d2_r <= 4'h0;
            d3_r <= 4'h0;
            flag_r <= 4'h0;
        end else begin
            d1_r <= det_in;
            d2_r <= d1_r;
            d3_r <= d2_r;
            flag_r <= flag_nxt;
        end
    end

    logic ovl_a, ovl_b, ovheat, low_sup;
    assign ovl_a = flag_r[0];
    assign ovl_b = flag_r[1];
    assign ovheat = flag_r[2];
    assign low_sup = flag_r[3];

    logic [7:0] diag;
    always_comb begin
        diag = lnbps_pkg::STATUS_RESET;
        diag[lnbps_pkg::DIAG_OVL_A] = ovl_a;
        diag[lnbps_pkg::DIAG_OVL_B] = ovl_b;
        diag[lnbps_pkg::DIAG_OVERHEAT] = ovheat;
        diag[lnbps_pkg::DIAG_LOW_SUPPLY] = low_sup;
    end

    // ************************************************************
    // Data registers and protection
    // ************************************************************
    logic [7:0] output_voltage_select_r, output_voltage_select_nxt, tone_r, tone_nxt;
    logic [7:0] pulse_r, pulse_nxt, policy_r, policy_nxt;
    logic en_a_r, en_a_nxt, en_b_r, en_b_nxt;
    logic ovl_clear, thermal_restart_policy_clear;

    assign ovl_clear = policy_r[lnbps_pkg::POL_OVL_RESTART] &
                       (ovl_a | ovl_b);
    assign thermal_restart_policy_clear = policy_r[lnbps_pkg::POL_THERMAL_RESTART_POLICY_RESTART] & ovheat;

    always_comb begin
        output_voltage_select_nxt = output_voltage_select_r;
        tone_nxt = tone_r;
        pulse_nxt = pulse_r;
        policy_nxt = policy_r;
        // Writes to the status indices fall through and change nothing
        if (bus.wr_en) begin
            if (bus.addr == lnbps_pkg::IDX_OUTPUT_VOLTAGE_SELECT) begin
                output_voltage_select_nxt = bus.wr_data;
            end
            if (bus.addr == lnbps_pkg::IDX_TONE) begin
                tone_nxt = bus.wr_data;
            end
            if (bus.addr == lnbps_pkg::IDX_PULSE) begin
                pulse_nxt = bus.wr_data;
            end
            if (bus.addr == lnbps_pkg::IDX_POLICY) begin
                policy_nxt = bus.wr_data;
            end
        end
        // Held clear while the fault stands, so a rewrite during the
        // fault is lost; the master must rewrite after it ends
        if (ovl_clear) begin
            output_voltage_select_nxt = lnbps_pkg::DATA_RESET;
        end
        if (thermal_restart_policy_clear) begin
            output_voltage_select_nxt = lnbps_pkg::DATA_RESET;
        end
        // Output off while its fault stands, back on with the kept
        // selection once the fault clears under the auto policy
        en_a_nxt = (output_voltage_select_r[3:0] != 4'h0) & ~ovl_a & ~ovheat;
        en_b_nxt = (output_voltage_select_r[7:4] != 4'h0) & ~ovl_b & ~ovheat;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            output_voltage_select_r <= lnbps_pkg::DATA_RESET;
            tone_r <= lnbps_pkg::DATA_RESET;
            pulse_r <= lnbps_pkg::DATA_RESET;
            policy_r <= lnbps_pkg::DATA_RESET;
            en_a_r <= 1'b0;
            en_b_r <= 1'b0;
        end else begin
            output_voltage_select_r <= output_voltage_select_nxt;
            tone_r <= tone_nxt;
            pulse_r <= pulse_nxt;
            policy_r <= policy_nxt;
            en_a_r <= en_a_nxt;
            en_b_r <= en_b_nxt;
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        unique case (bus.addr)
            lnbps_pkg::IDX_DIAG: bus.rd_data = diag;
            lnbps_pkg::IDX_SPARE: bus.rd_data = lnbps_pkg::STATUS_RESET;
            lnbps_pkg::IDX_OUTPUT_VOLTAGE_SELECT: bus.rd_data = output_voltage_select_r;
            lnbps_pkg::IDX_TONE: bus.rd_data = tone_r;
            lnbps_pkg::IDX_PULSE: bus.rd_data = pulse_r;
            lnbps_pkg::IDX_POLICY: bus.rd_data = policy_r;
            default: bus.rd_data = lnbps_pkg::UNMAPPED_READ;
        endcase
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign output_voltage_select_a = output_voltage_select_r[3:0];
    assign output_voltage_select_b = output_voltage_select_r[7:4];
    assign antenna_supply_output_en_a = en_a_r;
    assign antenna_supply_output_en_b = en_b_r;
    assign boost_comp_low_esr = policy_r[lnbps_pkg::POL_COMP];
    assign pulse_limit_disable_a = pulse_r[lnbps_pkg::PCL_A];
    assign pulse_limit_disable_b = pulse_r[lnbps_pkg::PCL_B];
    assign tone_ctrl = tone_r;

endmodule : lnbps_regs

//--- verif/lnbps_regs_asserts.sv
// Port checker for the protection and status register bank.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module lnbps_regs_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic overload_det_a,
    input wire logic overload_det_b,
    input wire logic overheat_det,
    input wire logic [3:0] output_voltage_select_a,
    input wire logic [3:0] output_voltage_select_b,
    input wire logic antenna_supply_output_en_a,
    input wire logic antenna_supply_output_en_b,
    input wire logic boost_comp_low_esr
);
    // ************************************************************
    // Protection and register relations
    // ************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Margin over the 5 mclk sync and reaction latency
    AST_OVL_A_OFF: assert property (
        overload_det_a [*8] |-> !antenna_supply_output_en_a)
        else $error("channel A output on during overload");
    AST_OVL_B_OFF: assert property (
        overload_det_b [*8] |-> !antenna_supply_output_en_b)
        else $error("channel B output on during overload");
    AST_HEAT_OFF: assert property (
        overheat_det [*8] |-> !antenna_supply_output_en_a
        && !antenna_supply_output_en_b)
        else $error("output on during overheat");
    AST_EN_NEEDS_SEL: assert property (
        (output_voltage_select_a == 4'h0) [*2]
        |-> !antenna_supply_output_en_a)
        else $error("channel A on with zero selection");
    AST_RESUME_A: assert property (
        (!overload_det_a && !overheat_det
        && output_voltage_select_a != 4'h0) [*8]
        |-> antenna_supply_output_en_a)
        else $error("channel A did not resume");
    AST_RESUME_B: assert property (
        (!overload_det_b && !overheat_det
        && output_voltage_select_b != 4'h0) [*8]
        |-> antenna_supply_output_en_b)
        else $error("channel B did not resume");
    // Bus writes land while scl is low, so a change with scl high
    // can only be a protection clear
    AST_PROT_CLEAR_BOTH: assert property (
        $changed({output_voltage_select_b, output_voltage_select_a})
        && scl_i |-> {output_voltage_select_b,
        output_voltage_select_a} == 8'h00)
        else $error("selection changed outside bus write");
    AST_COMP_ON_BUS: assert property (
        $changed(boost_comp_low_esr) |-> !scl_i)
        else $error("compensation changed outside bus write");
endmodule : lnbps_regs_asserts

bind lnbps_regs lnbps_regs_asserts i_chk (
    .mclk(mclk), .reset_n(reset_n), .scl_i(scl_i),
    .overload_det_a(overload_det_a), .overload_det_b(overload_det_b),
    .overheat_det(overheat_det),
    .output_voltage_select_a(output_voltage_select_a),
    .output_voltage_select_b(output_voltage_select_b),
    .antenna_supply_output_en_a(antenna_supply_output_en_a),
    .antenna_supply_output_en_b(antenna_supply_output_en_b),
    .boost_comp_low_esr(boost_comp_low_esr));

//--- verif/lnbps_master.sv
// Two-wire bus master model for the register bank's serial port.
// Assumes the testbench resolves the open-drain data wire with pull-up.
`timescale 1ns/1ps
module lnbps_master (
    input wire logic mclk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_m
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    // Phases well above the five mclk the port needs
    localparam int HALF = 10;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic start();
        sda_m = 1'b0;
        tick(HALF);
        scl = 1'b0;
        tick(2);
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_m = 1'b1;
        tick(HALF);
    endtask : stop
    // Data moves 2 mclk after scl falls so no false start is seen
    task automatic xfer(input logic b, output logic s);
        sda_m = b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF / 2);
        s = sda_in;
        tick(HALF / 2);
        scl = 1'b0;
        tick(2);
    endtask : xfer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
        ack = ~s;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, s);
    endtask : rd_byte
endmodule : lnbps_master

//--- verif/tb_lnbps_regs.sv
// Self-checking bench for the protection and status register bank.
// Assumes the master model and the bound port checker.
`timescale 1ns/1ps
module tb_lnbps_regs;
    logic mclk;
    logic reset_n;
    logic scl, m_sda, sda, sda_o, sda_oe;
    logic [3:0] det;
    logic [3:0] sel_a, sel_b;
    logic en_a, en_b, comp, pcl_a, pcl_b;
    logic [7:0] tone;
    int fail_count = 0;
    int n_tests = 0;
    assign sda = m_sda & ~(sda_oe & ~sda_o);
    lnbps_regs i_dut (.mclk(mclk), .reset_n(reset_n), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .overload_det_a(det[0]), .overload_det_b(det[1]),
        .overheat_det(det[2]), .low_supply_detector(det[3]),
        .output_voltage_select_a(sel_a), .output_voltage_select_b(sel_b),
        .antenna_supply_output_en_a(en_a),
        .antenna_supply_output_en_b(en_b), .boost_comp_low_esr(comp),
        .pulse_limit_disable_a(pcl_a), .pulse_limit_disable_b(pcl_b),
        .tone_ctrl(tone));
    lnbps_master i_master (.mclk(mclk), .sda_in(sda), .scl(scl),
        .sda_m(m_sda));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic send(input logic [7:0] d);
        logic a;
        i_master.wr_byte(d, a);
        chk("ack", 8'h01, {7'h00, a});
    endtask : send
    task automatic wr_reg(input logic [7:0] idx, d);
        i_master.start();
        send({lnbps_pkg::CHIP_ADDR, 1'b0});
        send(idx);
        send(d);
        i_master.stop();
    endtask : wr_reg
    task automatic chk_reg(input string what, input logic [7:0] idx, exp);
        logic [7:0] d;
        i_master.start();
        send({lnbps_pkg::CHIP_ADDR, 1'b0});
        send(idx);
        i_master.stop();
        i_master.start();
        send({lnbps_pkg::CHIP_ADDR, 1'b1});
        i_master.rd_byte(1'b1, d);
        i_master.stop();
        chk(what, exp, d);
    endtask : chk_reg
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        chk("sel", 8'h00, {sel_b, sel_a});
        chk_reg("diag", 8'h00, 8'h00);
        chk_reg("spare", 8'h01, 8'h00);
    endtask : t_reset
    task automatic t_readback();
        logic [7:0] v [4] = '{8'h35, 8'ha5, 8'h44, 8'h80};
        logic [7:0] d;
        // One burst each way, so pointer auto-increment is exercised
        i_master.start();
        send({lnbps_pkg::CHIP_ADDR, 1'b0});
        send(8'h02);
        for (int i = 0; i < 4; i++) send(v[i]);
        i_master.stop();
        for (int i = 0; i < 4; i++) chk_reg("data", 8'(i + 2), v[i]);
        i_master.start();
        send({lnbps_pkg::CHIP_ADDR, 1'b0});
        send(8'h02);
        i_master.stop();
        i_master.start();
        send({lnbps_pkg::CHIP_ADDR, 1'b1});
        for (int i = 0; i < 4; i++) begin
            i_master.rd_byte(i == 3, d);
            chk("burst", v[i], d);
        end
        i_master.stop();
        chk("sel", 8'h35, {sel_b, sel_a});
        chk("tone", 8'ha5, tone);
        chk("pcl", 8'h03, {6'h00, pcl_b, pcl_a});
        chk("comp", 8'h01, {7'h00, comp});
        wr_reg(8'h05, 8'h00);
        chk("comp", 8'h00, {7'h00, comp});
    endtask : t_readback
    task automatic t_status();
        int pos [4] = '{0, 1, 6, 7};
        for (int i = 0; i < 4; i++) begin
            det = 4'h1 << i;
            i_master.tick(8);
            chk_reg("flag", 8'h00, 8'h01 << pos[i]);
            det = 4'h0;
            i_master.tick(8);
            chk_reg("flag off", 8'h00, 8'h00);
        end
    endtask : t_status
    task automatic t_ro();
        logic a;
        det = 4'h1;
        i_master.tick(8);
        wr_reg(8'h00, 8'hff);
        wr_reg(8'h01, 8'hff);
        wr_reg(8'h20, 8'hff);
        chk_reg("diag", 8'h00, 8'h01);
        chk_reg("spare", 8'h01, 8'h00);
        chk_reg("unmapped", 8'h20, 8'h00);
        det = 4'h0;
        i_master.start();
        i_master.wr_byte({lnbps_pkg::CHIP_ADDR ^ 7'h01, 1'b0}, a);
        i_master.stop();
        chk("foreign ack", 8'h00, {7'h00, a});
    endtask : t_ro
    task automatic t_prot(input logic pol, heat);
        wr_reg(8'h05, pol ? (heat ? 8'h40 : 8'h08) : 8'h00);
        wr_reg(8'h02, 8'h35);
        i_master.tick(8);
        chk("en on", 8'h03, {6'h00, en_b, en_a});
        det = heat ? 4'h4 : 4'h1;
        i_master.tick(10);
        chk("sel fault", pol ? 8'h00 : 8'h35, {sel_b, sel_a});
        chk("en fault", (pol | heat) ? 8'h00 : 8'h02, {6'h00, en_b, en_a});
        det = 4'h0;
        i_master.tick(10);
        chk("en after", pol ? 8'h00 : 8'h03, {6'h00, en_b, en_a});
        if (pol) begin
            wr_reg(8'h02, 8'h35);
            i_master.tick(8);
            chk("en rewrite", 8'h03, {6'h00, en_b, en_a});
        end
    endtask : t_prot
    // Reset in mid-run, with the bus idle after a stop
    task automatic t_midreset();
        wr_reg(8'h05, 8'h80);
        chk("comp set", 8'h01, {7'h00, comp});
        reset_n = 1'b0;
        i_master.tick(2);
        chk("sel rst", 8'h00, {sel_b, sel_a});
        chk("out rst", 8'h00, {3'h0, pcl_b, pcl_a, comp, en_b, en_a});
        reset_n = 1'b1;
        i_master.tick(5);
        chk_reg("policy rst", 8'h05, 8'h00);
        chk_reg("diag rst", 8'h00, 8'h00);
    endtask : t_midreset
    initial begin
        reset_n = 1'b0;
        det = 4'h0;
        repeat (6) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        i_master.tick(5);
        t_reset();
        t_readback();
        t_status();
        t_ro();
        t_prot(1'b1, 1'b0);
        t_prot(1'b0, 1'b0);
        t_prot(1'b1, 1'b1);
        t_prot(1'b0, 1'b1);
        t_midreset();
        finish_test();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule : tb_lnbps_regs
